// File: tick_timer_regs.svh
/*
  register offsets, field positions, reset values and timing for the
  periodic tick timer.
  assumes: included by the package and by the timer modules.
*/
`ifndef TICK_TIMER_REGS_SVH
`define TICK_TIMER_REGS_SVH

// ===========================================================
// register byte offsets within the system control space
`define TICK_CTRL_OFS      12'h010
`define TICK_RELOAD_OFS    12'h014
`define TICK_CURRENT_OFS   12'h018
`define TICK_CALIB_OFS     12'h01C

// ===========================================================
// control register fields
`define TICK_ENABLE_BIT    0
`define TICK_EXC_EN_BIT    1
`define TICK_SRC_BIT       2
`define TICK_WRAP_BIT      16

// ===========================================================
// calibration register fields
`define TICK_NO_REF_CLOCK_INDICATOR_BIT     31
`define TICK_SKEW_BIT      30

// ===========================================================
// reset values and widths
`define TICK_CTRL_RESET    32'h0000_0000
`define TICK_COUNT_W       24
`define TICK_REF_DIV       8

`endif

// File: tick_timer_pkg.sv
/*
  types shared by the tick timer modules.
  assumes: tick_timer_regs.svh is reachable on the include path.
*/
package tick_timer_pkg;
`include "tick_timer_regs.svh"

  // register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

  // control bits held by software
  typedef struct packed {
    logic enable;
    logic exc_en;
    logic src_cpu;
  } tick_ctrl_s;
endpackage

// File: ref_tick_divider.sv
/*
  divides ref_clk into a one-cycle enable that stands in for the
  external reference clock.
  assumes: one clock domain, asynchronous active low reset.
*/
`timescale 1ns/1ns
`include "tick_timer_regs.svh"
module ref_tick_divider
  import tick_timer_pkg::*;
#(
  parameter int DIV = `TICK_REF_DIV
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // enable out
  output logic      ref_tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } div_state_s;

  div_state_s state_reg;
  div_state_s state_next;

  // ===========================================================
  // free running divider, pulse on wrap
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.cnt == 16'(DIV - 1)) begin
      state_next.cnt = 16'h0000;
      state_next.tick = 1'b1;
    end else begin
      state_next.cnt = state_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ref_tick = state_reg.tick;

  // ===========================================================
  // checks, all on the one clock
  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // pulse spacing is exactly DIV cycles
  tick_spacing_a: assert property (
    state_reg.tick |-> ##(DIV) state_reg.tick)
    else $error("reference tick spacing wrong");
endmodule

// File: periodic_tick_timer.sv
/*
  periodic tick timer: 24-bit down counter with reload, wrap flag,
  exception request and a read-only calibration word.
  assumes: registers are reached over a plain strobe port with read
  data one cycle later; the core keeps word accesses only.
*/
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`include "tick_timer_regs.svh"
module periodic_tick_timer
  import tick_timer_pkg::*;
#(
  parameter int CW  = `TICK_COUNT_W,
  parameter int DIV = `TICK_REF_DIV
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // exception request to the core
  output logic             tick_exc_req
);
  typedef struct packed {
    tick_ctrl_s    ctrl;
    logic          wrap_flag;
    logic [CW-1:0] reload;
    logic [CW-1:0] count;
    logic          exc;
    logic          arm;
    logic [31:0]   rdata;
  } timer_state_s;

  timer_state_s state_reg;
  timer_state_s state_next;
  bus_req_s     req;
  logic         ref_tick;
  logic         step;
  logic         zero_hit;

  // ===========================================================
  // reference clock stand-in
  ref_tick_divider #(.DIV(DIV)) u_ref_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .ref_tick (ref_tick)
  );

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr,
                 wdata: reg_wdata};

  // ===========================================================
  // counting clock select and zero event
  assign step = state_reg.ctrl.enable &&
                (state_reg.ctrl.src_cpu || ref_tick);
  // only a step from one to zero counts, so a zero reload is silent
  assign zero_hit = step && !state_reg.arm &&
                    (state_reg.count == CW'(1));

  // ===========================================================
  // next state: counter, flags and register port
  always_comb begin
    state_next = state_reg;
    state_next.exc = 1'b0;
    state_next.rdata = 32'h0000_0000;

    // counter path
    if (step) begin
      if (state_reg.arm || state_reg.count == '0) begin
        state_next.count = state_reg.reload;
        state_next.arm = 1'b0;
      end else begin
        state_next.count = state_reg.count - CW'(1);
      end
    end

    // read data; reading control clears the wrap flag
    if (req.rd) begin
      if (req.addr == `TICK_CTRL_OFS) begin
        state_next.rdata[`TICK_ENABLE_BIT] = state_reg.ctrl.enable;
        state_next.rdata[`TICK_EXC_EN_BIT] = state_reg.ctrl.exc_en;
        state_next.rdata[`TICK_SRC_BIT]    = state_reg.ctrl.src_cpu;
        state_next.rdata[`TICK_WRAP_BIT]   = state_reg.wrap_flag;
        state_next.wrap_flag = 1'b0;
      end else if (req.addr == `TICK_RELOAD_OFS) begin
        state_next.rdata[CW-1:0] = state_reg.reload;
      end else if (req.addr == `TICK_CURRENT_OFS) begin
        state_next.rdata[CW-1:0] = state_reg.count;
      end else if (req.addr == `TICK_CALIB_OFS) begin
        // reference present, no skew, no calibration count
        state_next.rdata = 32'h0000_0000;
      end
    end

    // writes
    if (req.wr) begin
      if (req.addr == `TICK_CTRL_OFS) begin
        state_next.ctrl.enable  = req.wdata[`TICK_ENABLE_BIT];
        state_next.ctrl.exc_en  = req.wdata[`TICK_EXC_EN_BIT];
        state_next.ctrl.src_cpu = req.wdata[`TICK_SRC_BIT];
        // a fresh enable loads reload on its first counting step
        if (req.wdata[`TICK_ENABLE_BIT] && !state_reg.ctrl.enable) begin
          state_next.arm = 1'b1;
        end
      end else if (req.addr == `TICK_RELOAD_OFS) begin
        state_next.reload = req.wdata[CW-1:0];
      end else if (req.addr == `TICK_CURRENT_OFS) begin
        state_next.count = '0;
        state_next.wrap_flag = 1'b0;
      end
    end

    // zero event: set wins over any clear in the same cycle
    if (zero_hit) begin
      state_next.wrap_flag = 1'b1;
      state_next.exc = state_reg.ctrl.exc_en;
    end
  end

  // ===========================================================
  // state register; reload and count have no documented reset,
  // cleared anyway so simulation starts defined
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign tick_exc_req = state_reg.exc;

  // ===========================================================
  // check helper: counting steps between two zero events
  // a period is judged only between two zero events with no
  // control, reload or current write between them, since such a write may move the count
  logic [CW-1:0] gap_steps_reg;
  logic          gap_valid_reg;
  logic          cfg_write;

  assign cfg_write = req.wr && (req.addr == `TICK_CTRL_OFS ||
                                req.addr == `TICK_RELOAD_OFS ||
                                req.addr == `TICK_CURRENT_OFS);

  // step tally, restarted at every zero event
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_steps_reg <= '0;
      gap_valid_reg <= 1'b0;
    end else begin
      if (zero_hit) begin
        gap_steps_reg <= '0;
      end else if (step) begin
        gap_steps_reg <= gap_steps_reg + CW'(1);
      end
      if (cfg_write) begin
        gap_valid_reg <= 1'b0;
      end else if (zero_hit) begin
        gap_valid_reg <= 1'b1;
      end
    end
  end

  // ===========================================================
  // checks, all on the one clock
  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // the step that takes the count from one to zero
  sequence zero_step_s;
    step && !state_reg.arm && state_reg.count == CW'(1);
  endsequence

  // the first counting step after a fresh enable
  sequence arm_step_s;
    step && state_reg.arm && !req.wr;
  endsequence

  // a read of the control word
  sequence ctrl_read_s;
    req.rd && req.addr == `TICK_CTRL_OFS;
  endsequence

  // a read of the current value
  sequence current_read_s;
    req.rd && req.addr == `TICK_CURRENT_OFS;
  endsequence

  // disabled counter moves only on a current write
  stopped_hold_a: assert property (
    !state_reg.ctrl.enable && !req.wr |=> $stable(state_reg.count))
    else $error("counter moved while disabled");

  // request follows the zero step when enabled
  exc_on_zero_a: assert property (
    zero_step_s |=> tick_exc_req == $past(state_reg.ctrl.exc_en))
    else $error("exception request wrong at zero");

  // no request without a zero step
  exc_cause_a: assert property (
    tick_exc_req |-> $past(zero_hit))
    else $error("exception request without zero");

  // request is a single pulse
  exc_pulse_a: assert property (
    tick_exc_req |=> !tick_exc_req)
    else $error("exception request longer than one cycle");

  // reference source waits for the reference tick
  ref_source_a: assert property (
    state_reg.ctrl.enable && !state_reg.ctrl.src_cpu && !ref_tick
    && !req.wr |=> $stable(state_reg.count))
    else $error("counted without reference tick");

  // reference source counts on each reference tick
  ref_step_a: assert property (
    state_reg.ctrl.enable && !state_reg.ctrl.src_cpu && ref_tick
    && !state_reg.arm && state_reg.count != '0 && !req.wr
    |=> state_reg.count == $past(state_reg.count) - CW'(1))
    else $error("reference tick did not count");

  // processor source counts every cycle
  cpu_source_a: assert property (
    state_reg.ctrl.enable && state_reg.ctrl.src_cpu
    && !state_reg.arm && state_reg.count != '0 && !req.wr
    |=> state_reg.count == $past(state_reg.count) - CW'(1))
    else $error("processor clock did not count");

  // zero step sets the wrap flag
  wrap_set_a: assert property (
    zero_step_s |=> state_reg.wrap_flag)
    else $error("wrap flag not set at zero");

  // control read clears the flag unless a zero lands with it
  wrap_clear_a: assert property (
    req.rd && req.addr == `TICK_CTRL_OFS && !zero_hit
    |=> !state_reg.wrap_flag)
    else $error("wrap flag survived a read");

  // flag is sticky until read or current write
  wrap_hold_a: assert property (
    state_reg.wrap_flag && !(req.rd && req.addr == `TICK_CTRL_OFS)
    && !(req.wr && req.addr == `TICK_CURRENT_OFS)
    |=> state_reg.wrap_flag)
    else $error("wrap flag dropped on its own");

  // flag rises only from a zero step
  wrap_cause_a: assert property (
    $rose(state_reg.wrap_flag) |-> $past(zero_hit))
    else $error("wrap flag set without zero");

  // control read returns the flag as it stood
  wrap_read_a: assert property (
    ctrl_read_s
    |=> reg_rdata[`TICK_WRAP_BIT] == $past(state_reg.wrap_flag))
    else $error("wrap flag read wrong");

  // reserved control bits read zero
  ctrl_reserved_a: assert property (
    ctrl_read_s |=> reg_rdata[31:17] == 15'h0000
    && reg_rdata[15:3] == 13'h0000)
    else $error("reserved control bits not zero");

  // step at zero reloads
  reload_zero_a: assert property (
    step && state_reg.count == '0 && !req.wr
    |=> state_reg.count == $past(state_reg.reload))
    else $error("reload not taken at zero");

  // first step after enabling reloads
  arm_load_a: assert property (
    arm_step_s |=> state_reg.count == $past(state_reg.reload)
    && !state_reg.arm)
    else $error("reload not taken on enable");

  // zero reload parks the counter with no request
  zero_silent_a: assert property (
    step && !state_reg.arm && state_reg.count == '0
    && state_reg.reload == '0 && !req.wr
    |=> state_reg.count == '0 && !tick_exc_req)
    else $error("zero reload not silent");

  // reload N-1 gives N steps from zero event to zero event
  period_a: assert property (
    zero_hit && gap_valid_reg |-> gap_steps_reg == state_reg.reload)
    else $error("zero event period wrong");

  // counter steps down by one
  count_step_a: assert property (
    step && !state_reg.arm && state_reg.count != '0 && !req.wr
    |=> state_reg.count == $past(state_reg.count) - CW'(1))
    else $error("counter did not step by one");

  // current write clears count and flag
  current_clear_a: assert property (
    req.wr && req.addr == `TICK_CURRENT_OFS && !zero_hit
    |=> state_reg.count == '0 && !state_reg.wrap_flag)
    else $error("current write did not clear");

  // current read returns the live count
  current_read_a: assert property (
    current_read_s |=> reg_rdata[CW-1:0] == $past(state_reg.count)
    && reg_rdata[31:CW] == '0)
    else $error("current value read wrong");

  // calibration word is all zero
  calib_zero_a: assert property (
    req.rd && req.addr == `TICK_CALIB_OFS |=> reg_rdata == 32'h0000_0000)
    else $error("calibration word not zero");
endmodule

// File: exc_sink.sv
/*
  stand-in for the core's exception logic: takes every tick request.
  assumes: shares the timer's clock and reset.
*/
`timescale 1ns/1ns
module exc_sink (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // request from the timer
  input  wire logic tick_exc_req,
  // tallies for the bench
  output int        hits,
  output int        gap
);
  int cyc;
  int last;

  // ==========================================================
  // request tally
  // gap is the cycle distance between the last two requests
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc  <= 0;
      last <= 0;
      hits <= 0;
      gap  <= 0;
    end else begin
      cyc <= cyc + 1;
      if (tick_exc_req === 1'b1) begin
        hits <= hits + 1;
        gap  <= cyc - last;
        last <= cyc;
      end
    end
  end
endmodule

// File: periodic_tick_timer_tb.sv
/*
  self-checking bench for the tick timer.
  assumes: register offsets from tick_timer_regs.svh; divider shortened.
*/
`timescale 1ns/1ns
`include "tick_timer_regs.svh"
module periodic_tick_timer_tb;
  localparam int DIV = 2;
  logic        ref_clk;
  logic        rst_n;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        tick_exc_req;
  logic [31:0] a;
  logic [31:0] b;
  int          hits;
  int          gap;
  int          h0;
  int          miscompares;
  int          total_checks;

  periodic_tick_timer #(.DIV(DIV)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tick_exc_req(tick_exc_req));
  exc_sink core (.ref_clk(ref_clk), .rst_n(rst_n),
    .tick_exc_req(tick_exc_req), .hits(hits), .gap(gap));

  // ==========================================================
  // clock and helpers
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the read edge
  task automatic rd(input logic [11:0] ad, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rc(input string n, input logic [11:0] ad,
                    input logic [31:0] e);
    logic [31:0] d;
    rd(ad, d);
    chk(n, e, d);
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rc("ctrl", `TICK_CTRL_OFS, 32'h0000_0000);
    rc("cur", `TICK_CURRENT_OFS, 32'h0000_0000);
    rc("calib", `TICK_CALIB_OFS, 32'h0000_0000);
    wr(`TICK_CALIB_OFS, 32'hFFFF_FFFF);
    rc("calib wr", `TICK_CALIB_OFS, 32'h0000_0000);
    rc("unmapped", 12'h020, 32'h0000_0000);
    wr(`TICK_RELOAD_OFS, 32'hFF12_3456);
    rc("reload", `TICK_RELOAD_OFS, 32'h0012_3456);
    wr(`TICK_CTRL_OFS, 32'hFFFE_FFF8);
    rc("ctrl rsvd", `TICK_CTRL_OFS, 32'h0000_0000);
  endtask

  // largest reload: live reads fall by the read spacing
  task automatic t_live;
    wr(`TICK_RELOAD_OFS, 32'h00FF_FFFF);
    wr(`TICK_CURRENT_OFS, 32'h0000_0000);
    wr(`TICK_CTRL_OFS, 32'h0000_0005);
    rd(`TICK_CURRENT_OFS, a);
    rd(`TICK_CURRENT_OFS, b);
    chk("live", a - 32'h2, b);
    wr(`TICK_CTRL_OFS, 32'h0000_0004);
    rd(`TICK_CURRENT_OFS, a);
    repeat (10) @(posedge ref_clk);
    rc("frozen", `TICK_CURRENT_OFS, a);
    wr(`TICK_CURRENT_OFS, 32'h1234_5678);
    rc("cleared", `TICK_CURRENT_OFS, 32'h0000_0000);
  endtask

  // reload 3 on the processor clock: request every 4 cycles
  task automatic t_cpu;
    wr(`TICK_RELOAD_OFS, 32'h0000_0003);
    h0 = hits;
    wr(`TICK_CTRL_OFS, 32'h0000_0007);
    repeat (20) @(posedge ref_clk);
    chk("period", 32'h4, 32'(gap));
    chk("requests", 32'h1, 32'(hits - h0 >= 4));
  endtask

  // no requests with exception enable off, flag still sticks
  task automatic t_noexc;
    wr(`TICK_CTRL_OFS, 32'h0000_0000);
    rd(`TICK_CTRL_OFS, a);
    h0 = hits;
    wr(`TICK_CTRL_OFS, 32'h0000_0005);
    repeat (20) @(posedge ref_clk);
    wr(`TICK_CTRL_OFS, 32'h0000_0004);
    chk("no request", 32'(h0), 32'(hits));
    rc("wrap set", `TICK_CTRL_OFS, 32'h0001_0004);
    rc("wrap read", `TICK_CTRL_OFS, 32'h0000_0004);
  endtask

  // reference source steps once per divider period
  task automatic t_ref;
    wr(`TICK_CURRENT_OFS, 32'h0000_0000);
    wr(`TICK_CTRL_OFS, 32'h0000_0003);
    repeat (40) @(posedge ref_clk);
    chk("ref period", 32'(4 * DIV), 32'(gap));
  endtask

  // reload zero: counter parks at zero, silent
  task automatic t_zero;
    wr(`TICK_CTRL_OFS, 32'h0000_0000);
    wr(`TICK_RELOAD_OFS, 32'h0000_0000);
    wr(`TICK_CURRENT_OFS, 32'h0000_0000);
    h0 = hits;
    wr(`TICK_CTRL_OFS, 32'h0000_0007);
    repeat (20) @(posedge ref_clk);
    chk("zero reload", 32'(h0), 32'(hits));
    rc("zero wrap", `TICK_CTRL_OFS, 32'h0000_0007);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    rst_n     = 1'b0;
    reg_addr  = 12'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_live();
    t_cpu();
    t_noexc();
    t_ref();
    t_zero();
    end_of_test();
  end

  // whole run needs about two hundred cycles
  initial begin
    #80000;
    miscompares++;
    end_of_test();
  end
endmodule
